// *** logic/gp_timer_defines.vh ***
// Offsets, field positions, reset values and timing counts of the timer
`ifndef GP_TIMER_DEFINES_VH
`define GP_TIMER_DEFINES_VH
// Register byte offsets
`define OFS_CFG 8'h00
`define OFS_TIMER_A_MODE_FIELD 8'h04
`define OFS_TBMR 8'h08
`define OFS_CTL 8'h0c
`define OFS_IMR 8'h18
`define OFS_RIS 8'h1c
`define OFS_MIS 8'h20
`define OFS_ICR 8'h24
`define OFS_TAILR 8'h28
`define OFS_TBILR 8'h2c
`define OFS_TAMATCH 8'h30
`define OFS_TAPR 8'h38
`define OFS_TBPR 8'h3c
`define OFS_TAR 8'h48
`define OFS_TBR 8'h4c
// Configuration values
`define CFG_32T 3'h0
`define CFG_RTC 3'h1
`define CFG_16 3'h4
// Mode field values
`define MODE_ONESHOT 2'h1
`define MODE_PERIODIC 2'h2
// Control bit positions
`define CTL_TIMER_A_ENABLE_BIT 0
`define CTL_TIMER_A_STALL_EN 1
`define CTL_RTC_STALL_OVERRIDE 4
`define CTL_TIMER_A_ADC_TRIGGER_EN 5
`define CTL_TBEN 8
`define CTL_TIMER_B_STALL_EN 9
`define CTL_TBOTE 13
`define CTL_MASK 32'h0000_2333
// Status, mask and clear bit positions
`define IRQ_TATO 0
`define IRQ_RTC 3
`define IRQ_TBTO 8
`define IRQ_MASK 32'h0000_0109
// Reset values
`define RST_CNT 32'hffff_ffff
`define RST_ILR 32'hffff_ffff
`define RST_PR 16'h0000
`define RST_CFG 3'h0
`define RST_RTC_LOAD 32'h0000_0001
// RTC input and tick rates in Hz
`define RTC_IN_HZ 32768
`define RTC_TICK_HZ 1
`define RTC_DIV (`RTC_IN_HZ / `RTC_TICK_HZ)
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** logic/rtc_tick_divider.v ***
// Divider from the RTC input pin edges down to a one-second tick
`timescale 1ns/100ps
module rtc_tick_divider #(
	parameter DIV = 32768
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Control and pin
	input wire run,
	input wire pin_in,
	// One-cycle tick
	output reg tick
);
	reg pin_q;
	reg [31:0] div_q;
	wire rise = pin_in & ~pin_q;

	// Count rising edges; restart whenever the RTC is not running
	always @(posedge clk) begin
		if (!rst_n) begin
			pin_q <= 1'b0;
			div_q <= 32'h0;
			tick <= 1'b0;
		end else begin
			pin_q <= pin_in;
			tick <= 1'b0;
			if (!run) begin
				div_q <= 32'h0;
			end else if (rise) begin
				if (div_q == DIV - 1) begin
					div_q <= 32'h0;
					tick <= 1'b1;
				end else begin
					div_q <= div_q + 32'h1;
				end
			end
		end
	end
endmodule

// *** logic/gp_timer_block.v ***
// Dual 16-bit timer, chainable to 32 bits or RTC, with AXI4-Lite slave
//
// Summary of operation
// - Reset leaves block idle; counters and interval loads read all ones.
// - Reset clears both prescale registers and prescale counters.
// - Config 0 gives chained 32-bit timer, 1 gives 32-bit RTC.
// - Config 0x4 splits into two independent 16-bit timers.
// - 32-bit interval load write fills A load low, B load high.
// - 32-bit count read returns B count high, A count low.
// - Chained timer counts down; only A mode field picks one-shot/periodic.
// - Enabled chained timer counts down, reloads interval after zero.
// - At zero one-shot stops and clears enable; periodic keeps counting.
// - 32-bit timeout sets sticky A timeout status until cleared.
// - ADC trigger pulses on timeout only with trigger enable set.
// - Interval load write while running is taken next cycle.
// - Stall enable plus processor halt freezes that timer's count.
// - RTC counts up, starts at one on each selection from another config, compares match.
// - RTC pin at 32.768 kHz is divided to a one-hertz tick.
// - RTC equal to match rolls to zero and keeps counting.
// - RTC match sets sticky status, masked copy, cleared by clear bit.
// - RTC stall override keeps RTC running despite stall enables.
// - 16-bit timers count down with 8-bit prescaler, own mode field.
// - 16-bit zero reloads count and prescale; one-shot clears enable.
// - 16-bit timeout sets sticky status; masked copy when mask set.
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "gp_timer_defines.vh"
module gp_timer_block #(
	parameter RTC_DIV = `RTC_DIV
) (
	// Clock and reset
	input wire SYS_CLK,
	input wire RSTN,
	// AXI4-Lite write address
	input wire [31:0] AWADDR,
	input wire AWVALID,
	output reg AWREADY,
	// AXI4-Lite write data
	input wire [31:0] WDATA,
	input wire [3:0] WSTRB,
	input wire WVALID,
	output reg WREADY,
	// AXI4-Lite write response
	output reg [1:0] BRESP,
	output reg BVALID,
	input wire BREADY,
	// AXI4-Lite read
	input wire [31:0] ARADDR,
	input wire ARVALID,
	output reg ARREADY,
	output reg [31:0] RDATA,
	output reg [1:0] RRESP,
	output reg RVALID,
	input wire RREADY,
	// Device pins
	input wire CPU_HALT,
	input wire CAPTURE_PIN_EVEN_0,
	// Event outputs
	output reg ADC_TRIG,
	output reg TIMER_IRQ
);
	// Register state
	reg [2:0] cfg_q, cfg_d;
	reg [3:0] mode_q, mode_d;
	reg [31:0] ctl_q, ctl_d;
	reg [31:0] imr_q, imr_d;
	reg [31:0] ris_q, ris_d;
	reg [31:0] ilr_q, ilr_d;
	reg [31:0] match_q, match_d;
	reg [15:0] pr_q, pr_d;
	reg [15:0] pc_q, pc_d;
	reg [31:0] cnt_q, cnt_d;
	reg trig_d;
	// Bus holding registers
	reg [7:0] aw_addr_q;
	reg aw_have_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg w_have_q;
	// Combinational helpers
	reg [31:0] ris_set;
	reg [31:0] clr;
	reg [31:0] wv;
	wire rtc_tick;
	wire [31:0] n16_cnt;
	wire [15:0] n16_pc;
	wire [1:0] to16;
	wire [1:0] en_v = {ctl_q[`CTL_TBEN], ctl_q[`CTL_TIMER_A_ENABLE_BIT]};
	wire [1:0] stall_v = {ctl_q[`CTL_TIMER_B_STALL_EN], ctl_q[`CTL_TIMER_A_STALL_EN]};
	wire [1:0] ote_v = {ctl_q[`CTL_TBOTE], ctl_q[`CTL_TIMER_A_ADC_TRIGGER_EN]};
	wire wr_go = aw_have_q & w_have_q & ~BVALID;
	wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
		{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

	// Chained timer runs on A enable unless stalled by the halt
	wire run32 = ctl_q[`CTL_TIMER_A_ENABLE_BIT] &
		~(ctl_q[`CTL_TIMER_A_STALL_EN] & CPU_HALT);
	wire oneshot_a = (mode_q[1:0] == `MODE_ONESHOT);

	// RTC ignores stall enables once the override is set
	wire rtc_frz = CPU_HALT & (|stall_v) &
		~ctl_q[`CTL_RTC_STALL_OVERRIDE];
	wire rtc_run = (cfg_q == `CFG_RTC) & ctl_q[`CTL_TIMER_A_ENABLE_BIT] & ~rtc_frz;

	rtc_tick_divider #(
		.DIV(RTC_DIV)
	) u_div (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.run(rtc_run),
		.pin_in(CAPTURE_PIN_EVEN_0),
		.tick(rtc_tick)
	);

	// Per-timer 16-bit down-counter with prescaler
	genvar n;
	generate
		for (n = 0; n < 2; n = n + 1) begin : g_tmr
			wire [15:0] c = cnt_q[16*n +: 16];
			wire [7:0] p = pc_q[8*n +: 8];
			wire [1:0] m = mode_q[2*n +: 2];
			wire mode_ok = (m == `MODE_ONESHOT) | (m == `MODE_PERIODIC);
			wire run = en_v[n] & mode_ok &
				~(stall_v[n] & CPU_HALT);
			wire zero = (c == 16'h0000) & (p == 8'h00);
			assign to16[n] = run & zero;
			// Prescale of zero lets the count move every clock
			assign n16_cnt[16*n +: 16] = !run ? c :
				(p != 8'h00) ? c :
				zero ? ilr_q[16*n +: 16] :
				c - 16'h0001;
			assign n16_pc[8*n +: 8] = !run ? p :
				(p != 8'h00) ? p - 8'h01 :
				pr_q[8*n +: 8];
		end
	endgenerate

	// Register readback; halves join in every configuration except the 16-bit one
	function [31:0] reg_val;
		input [7:0] a;
		begin
			case (a)
				`OFS_CFG: reg_val = {29'h0, cfg_q};
				`OFS_TIMER_A_MODE_FIELD: reg_val = {30'h0, mode_q[1:0]};
				`OFS_TBMR: reg_val = {30'h0, mode_q[3:2]};
				`OFS_CTL: reg_val = ctl_q;
				`OFS_IMR: reg_val = imr_q;
				`OFS_RIS: reg_val = ris_q;
				`OFS_MIS: reg_val = ris_q & imr_q;
				`OFS_TAILR: reg_val = (cfg_q == `CFG_16) ?
					{16'h0, ilr_q[15:0]} : ilr_q;
				`OFS_TBILR: reg_val = {16'h0, ilr_q[31:16]};
				`OFS_TAMATCH: reg_val = match_q;
				`OFS_TAPR: reg_val = {24'h0, pr_q[7:0]};
				`OFS_TBPR: reg_val = {24'h0, pr_q[15:8]};
				`OFS_TAR: reg_val = (cfg_q == `CFG_16) ?
					{16'h0, cnt_q[15:0]} : cnt_q;
				`OFS_TBR: reg_val = {16'h0, cnt_q[31:16]};
				default: reg_val = 32'h0;
			endcase
		end
	endfunction

	// Decode of mapped offsets; the clear register reads as zero
	function reg_hit;
		input [7:0] a;
		begin
			case (a)
				`OFS_CFG, `OFS_TIMER_A_MODE_FIELD, `OFS_TBMR, `OFS_CTL, `OFS_IMR,
				`OFS_RIS, `OFS_MIS, `OFS_ICR, `OFS_TAILR, `OFS_TBILR,
				`OFS_TAMATCH, `OFS_TAPR, `OFS_TBPR, `OFS_TAR,
				`OFS_TBR: reg_hit = 1'b1;
				default: reg_hit = 1'b0;
			endcase
		end
	endfunction

	// Counting first, then a software write overrides the same cycle
	always @* begin
		cfg_d = cfg_q;
		mode_d = mode_q;
		ctl_d = ctl_q;
		imr_d = imr_q;
		ilr_d = ilr_q;
		match_d = match_q;
		pr_d = pr_q;
		pc_d = pc_q;
		cnt_d = cnt_q;
		ris_set = 32'h0;
		clr = 32'h0;
		trig_d = 1'b0;
		wv = (reg_val(aw_addr_q) & ~wmask) | (w_data_q & wmask);
		case (cfg_q)
			`CFG_32T: begin
				if (run32) begin
					if (cnt_q == 32'h0) begin
						cnt_d = ilr_q;
						ris_set[`IRQ_TATO] = 1'b1;
						trig_d = ctl_q[`CTL_TIMER_A_ADC_TRIGGER_EN];
						if (oneshot_a) begin
							ctl_d[`CTL_TIMER_A_ENABLE_BIT] = 1'b0;
						end
					end else begin
						cnt_d = cnt_q - 32'h1;
					end
				end
			end
			`CFG_RTC: begin
				if (rtc_tick) begin
					if (cnt_q == match_q) begin
						cnt_d = 32'h0;
						ris_set[`IRQ_RTC] = 1'b1;
					end else begin
						cnt_d = cnt_q + 32'h1;
					end
				end
			end
			`CFG_16: begin
				cnt_d = n16_cnt;
				pc_d = n16_pc;
				ris_set[`IRQ_TATO] = to16[0];
				ris_set[`IRQ_TBTO] = to16[1];
				trig_d = |(to16 & ote_v);
				if (to16[0] & (mode_q[1:0] == `MODE_ONESHOT)) begin
					ctl_d[`CTL_TIMER_A_ENABLE_BIT] = 1'b0;
				end
				if (to16[1] & (mode_q[3:2] == `MODE_ONESHOT)) begin
					ctl_d[`CTL_TBEN] = 1'b0;
				end
			end
			default: begin
				cnt_d = cnt_q;
			end
		endcase
		if (wr_go) begin
			case (aw_addr_q)
				`OFS_CFG: begin
					cfg_d = wv[2:0];
					if ((wv[2:0] == `CFG_RTC) && (cfg_q != `CFG_RTC)) begin
						cnt_d = `RST_RTC_LOAD;
					end
				end
				`OFS_TIMER_A_MODE_FIELD: mode_d[1:0] = wv[1:0];
				`OFS_TBMR: mode_d[3:2] = wv[1:0];
				`OFS_CTL: ctl_d = wv & `CTL_MASK;
				`OFS_IMR: imr_d = wv & `IRQ_MASK;
				`OFS_ICR: clr = wv & `IRQ_MASK;
				`OFS_TAILR: begin
					if (cfg_q == `CFG_16) begin
						ilr_d[15:0] = wv[15:0];
						cnt_d[15:0] = wv[15:0];
					end else begin
						ilr_d = wv;
						cnt_d = wv;
					end
				end
				`OFS_TBILR: begin
					ilr_d[31:16] = wv[15:0];
					cnt_d[31:16] = wv[15:0];
				end
				`OFS_TAMATCH: match_d = wv;
				`OFS_TAPR: pr_d[7:0] = wv[7:0];
				`OFS_TBPR: pr_d[15:8] = wv[7:0];
				default: begin
					clr = 32'h0;
				end
			endcase
		end
		// A new event wins over a clear in the same cycle
		ris_d = (ris_q & ~clr) | ris_set;
	end

	// Timer state registers
	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			cfg_q <= `RST_CFG;
			mode_q <= 4'h0;
			ctl_q <= 32'h0;
			imr_q <= 32'h0;
			ris_q <= 32'h0;
			ilr_q <= `RST_ILR;
			match_q <= 32'h0;
			pr_q <= `RST_PR;
			pc_q <= `RST_PR;
			cnt_q <= `RST_CNT;
			ADC_TRIG <= 1'b0;
			TIMER_IRQ <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			mode_q <= mode_d;
			ctl_q <= ctl_d;
			imr_q <= imr_d;
			ris_q <= ris_d;
			ilr_q <= ilr_d;
			match_q <= match_d;
			pr_q <= pr_d;
			pc_q <= pc_d;
			cnt_q <= cnt_d;
			ADC_TRIG <= trig_d;
			TIMER_IRQ <= |(ris_d & imr_d);
		end
	end

	// Write channels: address and data are caught in either order
	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			AWREADY <= 1'b1;
			WREADY <= 1'b1;
			BVALID <= 1'b0;
			BRESP <= `RESP_OKAY;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_addr_q <= {AWADDR[7:2], 2'b00};
				aw_have_q <= 1'b1;
				AWREADY <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w_data_q <= WDATA;
				w_strb_q <= WSTRB;
				w_have_q <= 1'b1;
				WREADY <= 1'b0;
			end
			if (wr_go) begin
				BVALID <= 1'b1;
				BRESP <= reg_hit(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
			end
			// Ready again only after the response is taken
			if (BVALID && BREADY) begin
				BVALID <= 1'b0;
				AWREADY <= 1'b1;
				WREADY <= 1'b1;
			end
		end
	end

	// Read channel: data registered one cycle after the address
	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			ARREADY <= 1'b1;
			RVALID <= 1'b0;
			RDATA <= 32'h0;
			RRESP <= `RESP_OKAY;
		end else begin
			if (ARVALID && ARREADY) begin
				ARREADY <= 1'b0;
				RVALID <= 1'b1;
				RDATA <= reg_val({ARADDR[7:2], 2'b00});
				RRESP <= reg_hit({ARADDR[7:2], 2'b00}) ?
					`RESP_OKAY : `RESP_SLVERR;
			end
			if (RVALID && RREADY) begin
				RVALID <= 1'b0;
				ARREADY <= 1'b1;
			end
		end
	end
endmodule

// *** tb/gp_timer_block_sva.sv ***
// Checker of bus handshakes and reset state of the timer block
`timescale 1ns/100ps
module gp_timer_block_sva (
	// Clock and reset
	input wire SYS_CLK,
	input wire RSTN,
	// Bus handshakes
	input wire AWREADY,
	input wire WREADY,
	input wire [1:0] BRESP,
	input wire BVALID,
	input wire BREADY,
	input wire ARVALID,
	input wire ARREADY,
	input wire [31:0] RDATA,
	input wire [1:0] RRESP,
	input wire RVALID,
	input wire RREADY,
	// Events
	input wire ADC_TRIG,
	input wire TIMER_IRQ
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	// Reset itself is the cause here, so no disable
	a_reset_idle: assert property (disable iff (1'b0) !RSTN |=>
		AWREADY && ARREADY && !BVALID && !RVALID && !TIMER_IRQ && !ADC_TRIG)
		else $error("outputs not idle after reset");
	a_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped early");
	a_r_hold: assert property (RVALID && !RREADY |=>
		RVALID && $stable(RDATA) && $stable(RRESP))
		else $error("read data dropped early");
	a_r_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
		else $error("read not answered next cycle");
	a_b_after: assert property ($rose(BVALID) |-> !AWREADY && !WREADY)
		else $error("response before both channels");
	a_w_closed: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("write taken while response pending");
	a_b_release: assert property (BVALID && BREADY |=> !BVALID && AWREADY)
		else $error("write channel not reopened");
	a_r_closed: assert property (RVALID |-> !ARREADY)
		else $error("read taken while data pending");
	a_resp_code: assert property (BVALID |-> BRESP == 2'h0 || BRESP == 2'h2)
		else $error("bad write response code");
	c_slverr: cover property (BVALID && BREADY && BRESP == 2'h2);
	c_read: cover property (RVALID && RREADY);
	c_adc: cover property (ADC_TRIG);
	c_irq: cover property (TIMER_IRQ);
endmodule

// *** tb/tb_gp_timer_block.sv ***
// Randomised self-checking bench of the timer block
`timescale 1ns/100ps
`include "gp_timer_defines.vh"
module tb_gp_timer_block;
	logic SYS_CLK = 0;
	logic RSTN = 0;
	logic [31:0] AWADDR = 0, WDATA = 0, ARADDR = 0, d, e;
	logic [3:0] WSTRB = 4'hf;
	logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic CPU_HALT = 0, CAPTURE_PIN_EVEN_0 = 0;
	wire AWREADY, WREADY, BVALID, ARREADY, RVALID, ADC_TRIG, TIMER_IRQ;
	wire [1:0] BRESP, RRESP;
	wire [31:0] RDATA;
	int fail_count = 0, comparisons = 0, n, c, s;
	// Short divider keeps the clock test brief
	gp_timer_block #(.RTC_DIV(4)) u_gp_timer_block (.SYS_CLK(SYS_CLK),
		.RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
		.RVALID(RVALID), .RREADY(RREADY), .CPU_HALT(CPU_HALT),
		.CAPTURE_PIN_EVEN_0(CAPTURE_PIN_EVEN_0), .ADC_TRIG(ADC_TRIG),
		.TIMER_IRQ(TIMER_IRQ));
	always #12.5 SYS_CLK = ~SYS_CLK;
	// Cycles per period: prescale times count, both plus one
	function int p16(input int p, input int k);
		return (p + 1) * (k + 1);
	endfunction
	task chk(input [31:0] seen, input [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// A used-up bound means a hang
	task wt(input int k);
		if (k >= 3000) begin
			fail_count++;
			$display("[ERR] %0t timeout", $time);
			finish_test;
		end
	endtask
	task wr(input [7:0] a, input [31:0] x, input [31:0] r = 0);
		int k;
		AWADDR <= {24'h0, a};
		WDATA <= x;
		AWVALID <= 1;
		WVALID <= 1;
		BREADY <= 1;
		for (k = 0; k < 3000; k++) begin
			@(posedge SYS_CLK);
			if (AWREADY) AWVALID <= 0;
			if (WREADY) WVALID <= 0;
			if (BVALID === 1'b1) break;
		end
		wt(k);
		chk({30'h0, BRESP}, r);
		BREADY <= 0;
		@(posedge SYS_CLK);
	endtask
	task rd(input [7:0] a, output [31:0] x, input [31:0] r = 0);
		int k;
		ARADDR <= {24'h0, a};
		ARVALID <= 1;
		RREADY <= 1;
		for (k = 0; k < 3000; k++) begin
			@(posedge SYS_CLK);
			if (ARREADY) ARVALID <= 0;
			if (RVALID === 1'b1) break;
		end
		wt(k);
		x = RDATA;
		chk({30'h0, RRESP}, r);
		RREADY <= 0;
		@(posedge SYS_CLK);
	endtask
	task rc(input [7:0] a, input [31:0] x);
		rd(a, d);
		chk(d, x);
	endtask
	task wadc;
		int k;
		for (k = 0; k < 3000 && ADC_TRIG !== 1'b1; k++)
			@(posedge SYS_CLK);
		wt(k);
	endtask
	// Edges from one trigger pulse to the next
	task per(output int p);
		wadc;
		p = 0;
		do begin
			@(posedge SYS_CLK);
			p++;
		end while (ADC_TRIG !== 1'b1 && p < 3000);
		wt(p);
	endtask
	initial begin
		s = $urandom(13831);
		repeat (4) @(posedge SYS_CLK);
		RSTN <= 1;
		@(posedge SYS_CLK);
		rc(`OFS_TAR, 32'hffff_ffff);
		rc(`OFS_TAILR, 32'hffff_ffff);
		rc(`OFS_TAPR, 32'h0);
		rc(`OFS_CTL, 32'h0);
		rd(8'h44, d, 2);
		chk(d, 32'h0);
		wr(8'h44, 32'h1, 2);
		$display("reset test done");
		e = $urandom;
		wr(`OFS_TAILR, e);
		rc(`OFS_TAR, e);
		wr(`OFS_CFG, `CFG_16);
		rc(`OFS_TBILR, e >> 16);
		wr(`OFS_CFG, `CFG_32T);
		n = 5 + $urandom % 16;
		wr(`OFS_TAILR, n);
		wr(`OFS_TIMER_A_MODE_FIELD, `MODE_PERIODIC);
		// B asks for one-shot, which chained mode must ignore
		wr(`OFS_TBMR, `MODE_ONESHOT);
		wr(`OFS_CTL, 32'h21);
		per(c);
		chk(c, p16(0, n));
		n = 5 + $urandom % 16;
		wr(`OFS_TAILR, n);
		per(c);
		chk(c, p16(0, n));
		CPU_HALT <= 1;
		wr(`OFS_CTL, 32'h23);
		rd(`OFS_TAR, d);
		rc(`OFS_TAR, d);
		CPU_HALT <= 0;
		$display("periodic test done");
		wr(`OFS_CTL, 0);
		wr(`OFS_ICR, 32'h1);
		wr(`OFS_IMR, 32'h1);
		wr(`OFS_TIMER_A_MODE_FIELD, `MODE_ONESHOT);
		wr(`OFS_CTL, 32'h21);
		wadc;
		rc(`OFS_CTL, 32'h20);
		rc(`OFS_RIS, 32'h1);
		rc(`OFS_MIS, 32'h1);
		chk(TIMER_IRQ, 1);
		rc(`OFS_TAR, n);
		wr(`OFS_ICR, 32'h1);
		rc(`OFS_RIS, 32'h0);
		chk(TIMER_IRQ, 0);
		// Periodic without trigger enable: timeouts but no pulse
		wr(`OFS_TIMER_A_MODE_FIELD, `MODE_PERIODIC);
		wr(`OFS_CTL, 32'h1);
		c = 0;
		repeat (60) begin
			@(posedge SYS_CLK);
			if (ADC_TRIG === 1'b1) c++;
		end
		chk(c, 0);
		rc(`OFS_RIS, 32'h1);
		$display("one-shot test done");
		wr(`OFS_CTL, 0);
		wr(`OFS_CFG, `CFG_16);
		s = $urandom % 4;
		n = 3 + $urandom % 6;
		wr(`OFS_TBMR, `MODE_PERIODIC);
		// A one-shot beside a periodic B, so the halves must act alone
		wr(`OFS_TIMER_A_MODE_FIELD, `MODE_ONESHOT);
		wr(`OFS_TBPR, s);
		wr(`OFS_TBILR, n);
		wr(`OFS_TAILR, 3);
		wr(`OFS_ICR, 32'h109);
		wr(`OFS_CTL, 32'h2101);
		per(c);
		chk(c, p16(s, n));
		rc(`OFS_CTL, 32'h2100);
		rc(`OFS_RIS, 32'h101);
		$display("split test done");
		wr(`OFS_CTL, 0);
		wr(`OFS_CFG, `CFG_RTC);
		rc(`OFS_TAR, 32'h1);
		wr(`OFS_TAMATCH, 32'h3);
		wr(`OFS_IMR, 32'h8);
		wr(`OFS_ICR, 32'h109);
		// Halt with stall set, override keeps the clock running
		CPU_HALT <= 1;
		wr(`OFS_CTL, 32'h13);
		// Twelve rising input edges give three ticks
		repeat (24) begin
			CAPTURE_PIN_EVEN_0 <= ~CAPTURE_PIN_EVEN_0;
			repeat (3) @(posedge SYS_CLK);
		end
		rc(`OFS_RIS, 32'h8);
		rd(`OFS_TAR, d);
		chk(d, 32'h0);
		chk(TIMER_IRQ, 1);
		wr(`OFS_ICR, 32'h8);
		rc(`OFS_MIS, 32'h0);
		$display("rtc test done");
		finish_test;
	end
endmodule
bind gp_timer_block gp_timer_block_sva u_gp_timer_block_sva (
	.SYS_CLK(SYS_CLK), .RSTN(RSTN), .AWREADY(AWREADY), .WREADY(WREADY),
	.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
	.RREADY(RREADY), .ADC_TRIG(ADC_TRIG), .TIMER_IRQ(TIMER_IRQ));
